// [logic/pmc_cfg.svh]
// Purpose: register map, field positions, reset values and figures of the
//          power mode and clock divider control
// Assumes: byte addresses on a plain 8-bit register port, 32-bit data
// Notes:   definitions only
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// ==========================================================================
// register offsets
`define PMC_OFS_VREG      8'h00
`define PMC_OFS_PLL       8'h04
`define PMC_OFS_DIV       8'h08
`define PMC_OFS_STATUS    8'h0C
// ==========================================================================
// regulator control fields
`define PMC_VR_FREQUENCY  1:0
`define PMC_VR_LEVEL      7:4
`define PMC_FREQUENCY_OFF 2'h0
`define PMC_FREQUENCY_RST 2'h3
`define PMC_LEVEL_RST     4'h7
`define PMC_MV_BASE       11'h352
`define PMC_MV_STEP       11'h032
// ==========================================================================
// pll control fields
`define PMC_PLL_BYPASS    0
`define PMC_PLL_OFF       1
`define PMC_PLL_SLEEP     3
`define PMC_PLL_DEEP      5
`define PMC_PLL_MULT      14:9
`define PMC_MULT_RST      6'h0A
`define PMC_MULT_ZERO     6'h00
// ==========================================================================
// divider fields
`define PMC_DIV_SYS       3:0
`define PMC_DIV_CORE      5:4
`define PMC_SYS_RST       4'h5
`define PMC_CORE_RST      2'h0
`define PMC_SYS_ZERO      4'h0
`define PMC_SYS_ONE       4'h1
`define PMC_CORE_ONE      4'h1
`endif

// [logic/pmc_pkg.sv]
// Purpose: types shared by the power mode and clock divider control
// Assumes: nothing beyond the cfg header
// Notes:   operating modes and the carriers of the register port
package pmc_pkg;
  // ========================================================================
  // operating modes
  typedef enum logic [2:0] {
    PMC_FULL_ON,
    PMC_ACTIVE,
    PMC_SLEEP,
    PMC_DEEP_SLEEP,
    PMC_HIBERNATE
  } pmc_mode_e;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pmc_bus_s;

  // divided clocks and pll view
  typedef struct packed {
    logic       core_clock_tick;
    logic       sys_clock_tick;
    logic       pll_enabled;
    logic       pll_bypassed;
    logic [5:0] pll_multiplier;
  } pmc_clk_s;

  // supply and access view
  typedef struct packed {
    pmc_mode_e   mode;
    logic [10:0] core_voltage_mv;
    logic        internal_supply_on;
    logic        pins_hiz;
    logic        boot_start;
    logic        l1_dma_allow;
    logic        async_periph_allow;
  } pmc_pwr_s;
endpackage : pmc_pkg

// [logic/pmc_ctrl.sv]
// Purpose: power mode sequencing and core / system clock division
// Assumes: clock is the pll output stand-in; wake and reset pins are async
// Notes:   divided clocks leave as one-cycle ticks at the divided rate, in active mode every cycle
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "pmc_cfg.svh"
module pmc_ctrl
  import pmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire pmc_bus_s    bus,
  output logic [31:0]      rdata,
  input  wire logic        wake_pin,
  input  wire logic        reset_pin,
  output pmc_clk_s         clk_out,
  output pmc_pwr_s         pwr_out
);
  // ========================================================================
  // pin synchronisers
  logic wake_s1_reg, wake_s2_reg, rstp_s1_reg, rstp_s2_reg;

  // two flops per pin, only the second is read
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      rstp_s1_reg <= 1'b0;
      rstp_s2_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake_pin;
      wake_s2_reg <= wake_s1_reg;
      rstp_s1_reg <= reset_pin;
      rstp_s2_reg <= rstp_s1_reg;
    end
  end

  // ========================================================================
  // control registers and mode
  pmc_mode_e   mode_reg, mode_next;
  logic [1:0]  regulator_frequency_field_reg, regulator_frequency_field_next;
  logic [3:0]  level_reg, level_next;
  logic        bypass_reg, bypass_next;
  logic        pll_off_reg, pll_off_next;
  logic [5:0]  mult_reg, mult_next;
  logic [3:0]  sys_div_sel_reg, sys_div_sel_next;
  logic [1:0]  core_divider_select_reg, core_divider_select_next;
  logic        boot_reg, boot_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wr_ok, hib_req, sleep_cmd, deep_cmd;
  pmc_mode_e   resume_mode;

  // decode, register writes and mode sequencing
  always_comb begin
    regulator_frequency_field_next = regulator_frequency_field_reg;
    level_next  = level_reg;
    bypass_next = bypass_reg;
    pll_off_next = pll_off_reg;
    mult_next   = mult_reg;
    sys_div_sel_next = sys_div_sel_reg;
    core_divider_select_next = core_divider_select_reg;
    boot_next   = 1'b0;
    mode_next   = mode_reg;
    rdata_next  = 32'h0000_0000;
    // stopped clocks take no writes
    wr_ok = bus.wr && (mode_reg != PMC_DEEP_SLEEP) && (mode_reg != PMC_HIBERNATE);
    hib_req = wr_ok && (bus.addr == `PMC_OFS_VREG)
              && (bus.wdata[`PMC_VR_FREQUENCY] == `PMC_FREQUENCY_OFF);
    sleep_cmd = wr_ok && (bus.addr == `PMC_OFS_PLL) && bus.wdata[`PMC_PLL_SLEEP];
    deep_cmd  = wr_ok && (bus.addr == `PMC_OFS_PLL) && bus.wdata[`PMC_PLL_DEEP];
    resume_mode = bypass_reg ? PMC_ACTIVE : PMC_FULL_ON;
    if (wr_ok) begin
      case (bus.addr)
        `PMC_OFS_VREG: begin
          regulator_frequency_field_next = bus.wdata[`PMC_VR_FREQUENCY];
          level_next = bus.wdata[`PMC_VR_LEVEL];
        end
        `PMC_OFS_PLL: begin
          bypass_next  = bus.wdata[`PMC_PLL_BYPASS];
          pll_off_next = bus.wdata[`PMC_PLL_OFF];
          // zero is outside 1..63, keep old multiplier
          if (bus.wdata[`PMC_PLL_MULT] != `PMC_MULT_ZERO) begin
            mult_next = bus.wdata[`PMC_PLL_MULT];
          end
        end
        `PMC_OFS_DIV: begin
          sys_div_sel_next = bus.wdata[`PMC_DIV_SYS];
          core_divider_select_next = bus.wdata[`PMC_DIV_CORE];
        end
        default: begin
        end
      endcase
    end
    case (mode_reg)
      PMC_FULL_ON, PMC_ACTIVE: begin
        if (hib_req) begin
          mode_next = PMC_HIBERNATE;
        end else if (deep_cmd) begin
          mode_next = PMC_DEEP_SLEEP;
        end else if (sleep_cmd) begin
          mode_next = PMC_SLEEP;
        end else begin
          mode_next = bypass_next ? PMC_ACTIVE : PMC_FULL_ON;
        end
      end
      PMC_SLEEP: begin
        if (hib_req) begin
          mode_next = PMC_HIBERNATE;
        end else if (wake_s2_reg || rstp_s2_reg) begin
          mode_next = resume_mode;
        end
      end
      PMC_DEEP_SLEEP: begin
        if (rstp_s2_reg) begin
          mode_next = resume_mode;
        end
      end
      PMC_HIBERNATE: begin
        if (rstp_s2_reg) begin
          // state was lost with the supply: defaults, then boot
          regulator_frequency_field_next = `PMC_FREQUENCY_RST;
          level_next   = `PMC_LEVEL_RST;
          bypass_next  = 1'b0;
          pll_off_next = 1'b0;
          mult_next    = `PMC_MULT_RST;
          sys_div_sel_next = `PMC_SYS_RST;
          core_divider_select_next = `PMC_CORE_RST;
          boot_next    = 1'b1;
          mode_next    = PMC_FULL_ON;
        end
      end
      default: mode_next = PMC_FULL_ON;
    endcase
    // read data stands one cycle after the strobe
    if (bus.rd) begin
      case (bus.addr)
        `PMC_OFS_VREG:   rdata_next = {24'h00_0000, level_reg, 2'h0,
                                       regulator_frequency_field_reg};
        `PMC_OFS_PLL:    rdata_next = {17'h0_0000, mult_reg, 7'h00, pll_off_reg, bypass_reg};
        `PMC_OFS_DIV:    rdata_next = {26'h000_0000, core_divider_select_reg,
                                       sys_div_sel_reg};
        `PMC_OFS_STATUS: rdata_next = {29'h0000_0000, mode_reg};
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // control register stage
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_reg    <= PMC_FULL_ON;
      regulator_frequency_field_reg <= `PMC_FREQUENCY_RST;
      level_reg   <= `PMC_LEVEL_RST;
      bypass_reg  <= 1'b0;
      pll_off_reg <= 1'b0;
      mult_reg    <= `PMC_MULT_RST;
      sys_div_sel_reg <= `PMC_SYS_RST;
      core_divider_select_reg <= `PMC_CORE_RST;
      boot_reg    <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      mode_reg    <= mode_next;
      regulator_frequency_field_reg <= regulator_frequency_field_next;
      level_reg   <= level_next;
      bypass_reg  <= bypass_next;
      pll_off_reg <= pll_off_next;
      mult_reg    <= mult_next;
      sys_div_sel_reg <= sys_div_sel_next;
      core_divider_select_reg <= core_divider_select_next;
      boot_reg    <= boot_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ========================================================================
  // core and system dividers
  logic [2:0] ccnt_reg, ccnt_next;
  logic [3:0] scnt_reg, scnt_next;
  logic       ctick_reg, ctick_next, stick_reg, stick_next;
  logic       core_run, sys_run, bypassed;
  logic [3:0] sys_div_eff, cper;

  // a new divisor loads only when the count wraps
  always_comb begin
    bypassed = (mode_reg == PMC_ACTIVE);
    core_run = (mode_reg == PMC_FULL_ON) || bypassed;
    sys_run  = core_run || (mode_reg == PMC_SLEEP);
    sys_div_eff = (sys_div_sel_reg == `PMC_SYS_ZERO) ? `PMC_SYS_ONE
                                                      : sys_div_sel_reg;
    cper = `PMC_CORE_ONE << core_divider_select_reg;
    // bypass ticks every cycle at once, even with a count still pending
    ctick_next = core_run && ((ccnt_reg == 3'h0) || bypassed);
    stick_next = sys_run && ((scnt_reg == 4'h0) || bypassed);
    if (!core_run || bypassed) begin
      ccnt_next = 3'h0;
    end else if (ccnt_reg == 3'h0) begin
      ccnt_next = 3'(cper - `PMC_CORE_ONE);
    end else begin
      ccnt_next = ccnt_reg - 3'h1;
    end
    if (!sys_run || bypassed) begin
      scnt_next = 4'h0;
    end else if (scnt_reg == 4'h0) begin
      scnt_next = sys_div_eff - `PMC_SYS_ONE;
    end else begin
      scnt_next = scnt_reg - 4'h1;
    end
  end

  // divider stage
  always_ff @(posedge clock) begin
    if (rst) begin
      ccnt_reg  <= 3'h0;
      scnt_reg  <= 4'h0;
      ctick_reg <= 1'b0;
      stick_reg <= 1'b0;
    end else begin
      ccnt_reg  <= ccnt_next;
      scnt_reg  <= scnt_next;
      ctick_reg <= ctick_next;
      stick_reg <= stick_next;
    end
  end

  // ========================================================================
  // outputs
  assign rdata = rdata_reg;
  assign clk_out.core_clock_tick = ctick_reg;
  assign clk_out.sys_clock_tick  = stick_reg;
  assign clk_out.pll_enabled     = !pll_off_reg && (mode_reg != PMC_DEEP_SLEEP)
                                   && (mode_reg != PMC_HIBERNATE);
  assign clk_out.pll_bypassed    = bypassed;
  assign clk_out.pll_multiplier  = mult_reg;
  assign pwr_out.mode            = mode_reg;
  assign pwr_out.core_voltage_mv = `PMC_MV_BASE + 11'(level_reg) * `PMC_MV_STEP;
  assign pwr_out.internal_supply_on = (mode_reg != PMC_HIBERNATE);
  assign pwr_out.pins_hiz        = (mode_reg == PMC_HIBERNATE);
  assign pwr_out.boot_start      = boot_reg;
  assign pwr_out.l1_dma_allow    = (mode_reg == PMC_FULL_ON) || bypassed;
  assign pwr_out.async_periph_allow = (mode_reg != PMC_DEEP_SLEEP)
                                      && (mode_reg != PMC_HIBERNATE);

  // ========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_hib_entry: assert property (
    (mode_reg == PMC_FULL_ON) && hib_req |=> (mode_reg == PMC_HIBERNATE)
      && !pwr_out.internal_supply_on ##1 !ctick_reg && !stick_reg)
    else $error("hibernate not entered on supply code 00");
  chk_hib_pins: assert property (
    mode_reg == PMC_HIBERNATE |-> pwr_out.pins_hiz)
    else $error("pins driven in hibernate");
  chk_hib_wake: assert property (
    (mode_reg == PMC_HIBERNATE) && rstp_s2_reg |=> pwr_out.internal_supply_on
      && pwr_out.boot_start ##1 !pwr_out.boot_start)
    else $error("hibernate wake without supply or boot");
  chk_sleep_core: assert property (
    (mode_reg == PMC_SLEEP) && ($past(mode_reg) == PMC_SLEEP) |-> !ctick_reg)
    else $error("core clock runs in sleep");
  chk_sleep_sys: assert property (
    (mode_reg == PMC_SLEEP) && (scnt_reg == 4'h0) |=> stick_reg)
    else $error("system clock stopped in sleep");
  chk_sleep_wake: assert property (
    (mode_reg == PMC_SLEEP) && wake_s2_reg && !hib_req
      |=> mode_reg == ($past(bypass_reg) ? PMC_ACTIVE : PMC_FULL_ON))
    else $error("wrong mode after wakeup");
  chk_sleep_dma: assert property (
    mode_reg == PMC_SLEEP |-> !pwr_out.l1_dma_allow)
    else $error("dma to l1 allowed in sleep");
  chk_deep_hold: assert property (
    (mode_reg == PMC_DEEP_SLEEP) && !rstp_s2_reg |=> (mode_reg == PMC_DEEP_SLEEP)
      && !ctick_reg && !stick_reg)
    else $error("deep sleep left without reset");
  chk_deep_exit: assert property (
    (mode_reg == PMC_DEEP_SLEEP) && rstp_s2_reg
      |=> mode_reg == ($past(bypass_reg) ? PMC_ACTIVE : PMC_FULL_ON))
    else $error("wrong mode after deep sleep");
  chk_deep_async: assert property (
    mode_reg == PMC_DEEP_SLEEP |-> !pwr_out.async_periph_allow)
    else $error("async access open in deep sleep");
  chk_volt_step: assert property (
    wr_ok && (bus.addr == `PMC_OFS_VREG) && !hib_req |=> pwr_out.core_voltage_mv
      == `PMC_MV_BASE + 11'($past(bus.wdata[`PMC_VR_LEVEL])) * `PMC_MV_STEP)
    else $error("voltage not 50 mV per code");
  chk_active_rate: assert property (
    (mode_reg == PMC_ACTIVE) [*2] |-> ctick_reg && stick_reg)
    else $error("active clocks not at input rate");

  cov_sleep_wake: cover property (
    (mode_reg == PMC_SLEEP) ##1 (mode_reg == PMC_FULL_ON));
  cov_deep_active: cover property (
    (mode_reg == PMC_DEEP_SLEEP) ##1 (mode_reg == PMC_ACTIVE));
  cov_hib_boot: cover property (
    (mode_reg == PMC_HIBERNATE) ##1 pwr_out.boot_start);
endmodule : pmc_ctrl

// [verif/pmc_ctrl_tb_top.sv]
// Purpose: self-checking bench of the power mode and clock divider control
// Assumes: 20 MHz clock, one-cycle register strobes, read data one cycle later
// Notes:   tests are sequences of register accesses and pin events
`timescale 1ns/1ns
`include "pmc_cfg.svh"
module pmc_ctrl_tb_top
  import pmc_pkg::*;
;
  logic        clock;
  logic        rst;
  pmc_bus_s    bus;
  logic [31:0] rdata;
  logic        wake_pin;
  logic        reset_pin;
  pmc_clk_s    clk_out;
  pmc_pwr_s    pwr_out;
  int          fail_count;
  int          checked;
  int          cycles;
  int          c, s, b, n;
  int          codes[5] = '{1, 6, 10, 15, 0};

  pmc_ctrl dut (
    .clock     (clock),
    .rst       (rst),
    .bus       (bus),
    .rdata     (rdata),
    .wake_pin  (wake_pin),
    .reset_pin (reset_pin),
    .clk_out   (clk_out),
    .pwr_out   (pwr_out)
  );

  // ==========================================================================
  // clock and hang guard
  always #25 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("timeout after %0d cycles", cycles);
      conclude();
    end
  end

  // ==========================================================================
  // helpers
  task conclude;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task step;
    @(posedge clock);
    #1;
  endtask : step

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
    #1;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_reg

  function automatic logic tk(input logic core);
    return core ? clk_out.core_clock_tick === 1'b1 : clk_out.sys_clock_tick === 1'b1;
  endfunction : tk

  // cycles between two ticks; second gap so a new divisor has landed
  task per(input logic core, input int exp);
    int i;
    repeat (2) begin
      i = 0;
      step();
      while (!tk(core) && i < 40) begin
        step();
        i++;
      end
      n = 0;
      do begin
        step();
        n++;
      end while (!tk(core) && n < 40);
    end
    chk(32'(n), 32'(exp));
  endtask : per

  task cnt(input int k);
    c = 0;
    s = 0;
    b = 0;
    repeat (k) begin
      step();
      c += int'(clk_out.core_clock_tick === 1'b1);
      s += int'(clk_out.sys_clock_tick === 1'b1);
      b += int'(pwr_out.boot_start === 1'b1);
    end
  endtask : cnt

  // pin raised, mode settles three edges later
  task pin(input logic use_reset);
    @(posedge clock);
    if (use_reset) reset_pin <= 1'b1;
    else wake_pin <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
  endtask : pin

  task drop;
    @(posedge clock);
    wake_pin  <= 1'b0;
    reset_pin <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask : drop

  task mode_is(input pmc_mode_e m);
    chk(32'(pwr_out.mode), 32'(m));
  endtask : mode_is

  // ==========================================================================
  // main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    bus = '0;
    wake_pin = 1'b0;
    reset_pin = 1'b0;
    fail_count = 0;
    checked = 0;
    cycles = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd_reg(`PMC_OFS_VREG, 32'h73);
    rd_reg(`PMC_OFS_PLL, 32'h1400);
    rd_reg(`PMC_OFS_DIV, 32'h5);
    rd_reg(`PMC_OFS_STATUS, 32'h0);
    chk(32'(clk_out.pll_enabled), 32'h1);
    rd_reg(8'h10, 32'h0);
    $display("test reset values done");
    // voltage steps
    for (int l = 0; l < 16; l += 5) begin
      wr_reg(`PMC_OFS_VREG, {24'h0, 4'(l), 4'h3});
      chk(32'(pwr_out.core_voltage_mv), 32'(11'h352 + 11'h032 * 11'(l)));
    end
    wr_reg(`PMC_OFS_VREG, 32'h73);
    $display("test voltage done");
    // multiplier range, zero refused
    wr_reg(`PMC_OFS_PLL, 32'h7E00);
    chk(32'(clk_out.pll_multiplier), 32'h3F);
    wr_reg(`PMC_OFS_PLL, 32'h0);
    rd_reg(`PMC_OFS_PLL, 32'h7E00);
    wr_reg(`PMC_OFS_PLL, 32'h200);
    chk(32'(clk_out.pll_multiplier), 32'h1);
    wr_reg(`PMC_OFS_PLL, 32'h1400);
    $display("test multiplier done");
    // core and system dividers
    for (int k = 0; k < 4; k++) begin
      wr_reg(`PMC_OFS_DIV, 32'h5 | (32'(k) << 4));
      per(1'b1, 1 << k);
    end
    foreach (codes[i]) begin
      wr_reg(`PMC_OFS_DIV, 32'(codes[i]));
      per(1'b0, codes[i] == 0 ? 1 : codes[i]);
    end
    wr_reg(`PMC_OFS_DIV, 32'h5);
    $display("test dividers done");
    // active mode, pll off and on again, then sleep and wake back to active
    wr_reg(`PMC_OFS_PLL, 32'h1401);
    mode_is(PMC_ACTIVE);
    chk(32'(clk_out.pll_bypassed), 32'h1);
    per(1'b1, 1);
    per(1'b0, 1);
    wr_reg(`PMC_OFS_PLL, 32'h1403);
    chk(32'(clk_out.pll_enabled), 32'h0);
    mode_is(PMC_ACTIVE);
    wr_reg(`PMC_OFS_PLL, 32'h1401);
    chk(32'(clk_out.pll_enabled), 32'h1);
    wr_reg(`PMC_OFS_PLL, 32'h1409);
    mode_is(PMC_SLEEP);
    chk(32'(pwr_out.l1_dma_allow), 32'h0);
    cnt(20);
    chk(32'(c), 32'h0);
    chk(32'(s), 32'h4);
    rd_reg(`PMC_OFS_STATUS, 32'h2);
    pin(1'b0);
    mode_is(PMC_ACTIVE);
    drop();
    wr_reg(`PMC_OFS_PLL, 32'h1408);
    pin(1'b0);
    mode_is(PMC_FULL_ON);
    chk(32'(pwr_out.l1_dma_allow), 32'h1);
    drop();
    $display("test sleep done");
    // deep sleep: wakeup pin and writes have no effect
    wr_reg(`PMC_OFS_PLL, 32'h1420);
    mode_is(PMC_DEEP_SLEEP);
    chk(32'(pwr_out.async_periph_allow), 32'h0);
    chk(32'(clk_out.pll_enabled), 32'h0);
    cnt(20);
    chk(32'(c + s), 32'h0);
    pin(1'b0);
    mode_is(PMC_DEEP_SLEEP);
    drop();
    wr_reg(`PMC_OFS_DIV, 32'h3F);
    pin(1'b1);
    mode_is(PMC_FULL_ON);
    chk(32'(pwr_out.async_periph_allow), 32'h1);
    drop();
    rd_reg(`PMC_OFS_DIV, 32'h5);
    wr_reg(`PMC_OFS_PLL, 32'h1421);
    pin(1'b1);
    mode_is(PMC_ACTIVE);
    drop();
    wr_reg(`PMC_OFS_PLL, 32'h1400);
    $display("test deep sleep done");
    // hibernate and boot on reset pin; the boot pulse stands in the first cycle
    wr_reg(`PMC_OFS_DIV, 32'hF);
    wr_reg(`PMC_OFS_VREG, 32'h70);
    mode_is(PMC_HIBERNATE);
    chk(32'(pwr_out.internal_supply_on), 32'h0);
    chk(32'(pwr_out.pins_hiz), 32'h1);
    cnt(10);
    chk(32'(c + s + b), 32'h0);
    rd_reg(`PMC_OFS_STATUS, 32'h4);
    pin(1'b1);
    mode_is(PMC_FULL_ON);
    chk(32'(pwr_out.internal_supply_on), 32'h1);
    chk(32'(pwr_out.boot_start), 32'h1);
    chk(32'(pwr_out.pins_hiz), 32'h0);
    cnt(6);
    chk(32'(b), 32'h0);
    drop();
    rd_reg(`PMC_OFS_DIV, 32'h5);
    rd_reg(`PMC_OFS_VREG, 32'h73);
    $display("test hibernate done");
    conclude();
  end
endmodule : pmc_ctrl_tb_top
